// ---- neg_mac_low_halfword_tb_top.sv ----
`timescale 1ns/1ps
`include "nmac_consts.svh"

module neg_mac_low_halfword_tb_top;
    logic        clk;
    logic        rst_n;
    logic [7:0]  addr;
    logic [31:0] wr_data;
    logic        wr_en;
    logic        rd_en;
    logic [31:0] rd_data;
    logic        irq;
    logic        busy;
    int          n_mismatch;
    int          check_count;
    integer      seed;
    logic [31:0] exp_acc;
    logic [31:0] r;
    logic [31:0] got;

    nmac_low_core nmac_low_core_i (
        .clk     (clk),
        .rst_n   (rst_n),
        .addr    (addr),
        .wr_data (wr_data),
        .wr_en   (wr_en),
        .rd_en   (rd_en),
        .rd_data (rd_data),
        .irq     (irq),
        .busy    (busy)
    );

    nmac_host_model nmac_host_model_i (
        .clk     (clk),
        .addr    (addr),
        .wr_data (wr_data),
        .wr_en   (wr_en),
        .rd_en   (rd_en),
        .rd_data (rd_data)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ------------------------------------------------------------------------
    // checking
    // ------------------------------------------------------------------------
    task automatic cmp_word(input logic [31:0] g, input logic [31:0] e, input string m);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask

    task automatic cmp_bit(input logic g, input logic e, input string m);
        cmp_word({31'h0, g}, {31'h0, e}, m);
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // {overflow, stored value}
    function automatic logic [32:0] nmac_expect(input logic [31:0] a, input logic [31:0] b,
                                                input logic [31:0] acc, input logic sat);
        logic signed [31:0] p;
        logic [32:0]        d;
        logic               ov;
        p  = $signed(a[15:0]) * $signed(b[15:0]);
        d  = {acc[31], acc} - {p[31], p};
        ov = d[32] ^ d[31];
        if (sat && ov)
            return {1'b1, d[32] ? `SAT_NEG_VALUE : `SAT_POS_VALUE};
        return {ov, d[31:0]};
    endfunction

    // ------------------------------------------------------------------------
    // one operation with random flags, field and mask beforehand
    // ------------------------------------------------------------------------
    task automatic run_op(input logic [2:0] f, input logic [31:0] a, input logic [31:0] b,
                          input logic [31:0] acc, input logic chain);
        logic [32:0] e;
        logic [31:0] v;
        logic [1:0]  exc;
        logic [1:0]  mask;
        logic [1:0]  st;
        logic [3:0]  cr;
        v = $random(seed);
        exc = v[1:0];
        mask = v[3:2];
        cr = v[7:4];
        nmac_host_model_i.wr(`OFS_SRC_A, a);
        nmac_host_model_i.wr(`OFS_SRC_B, b);
        if (!chain)
            nmac_host_model_i.wr(`OFS_DEST_ACCUM, acc);
        nmac_host_model_i.wr(`OFS_FIXED_EXC, {30'h0, exc});
        nmac_host_model_i.wr(`OFS_COND_ZERO, {28'h0, cr});
        nmac_host_model_i.wr(`OFS_IRQ_STATUS, 32'h0000_0003);
        nmac_host_model_i.wr(`OFS_IRQ_MASK, {30'h0, mask});
        nmac_host_model_i.wr(`OFS_COMMAND, {29'h0, f});
        nmac_host_model_i.idle();
        #1 cmp_bit(busy, 1'b1, "busy high");
        @(posedge clk);
        #1 cmp_bit(busy, 1'b0, "busy low");
        e = nmac_expect(a, b, chain ? exp_acc : acc, f[0]);
        if (f[2])
            exc = {exc[1] | e[32], e[32]};
        if (f[1])
            cr = {e[31], ~e[31] & (|e[31:0]), ~(|e[31:0]), exc[1]};
        st = {e[32], 1'b1};
        cmp_bit(irq, |(st & mask), "irq level");
        nmac_host_model_i.rd(`OFS_DEST_ACCUM, got);
        cmp_word(got, e[31:0], "accumulator");
        nmac_host_model_i.rd(`OFS_FIXED_EXC, got);
        cmp_word(got, {30'h0, exc}, "overflow flags");
        nmac_host_model_i.rd(`OFS_COND_ZERO, got);
        cmp_word(got, {28'h0, cr}, "condition field");
        nmac_host_model_i.rd(`OFS_IRQ_STATUS, got);
        cmp_word(got, {30'h0, st}, "irq status");
        nmac_host_model_i.rd(`OFS_COMMAND, got);
        cmp_word(got, {29'h0, f}, "last form");
        exp_acc = e[31:0];
    endtask

    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial begin
        n_mismatch = 0;
        check_count = 0;
        seed = 32178;
        exp_acc = 32'h0000_0000;
        rst_n = 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i <= 8; i++) begin
            nmac_host_model_i.rd(8'(i * 4), got);
            cmp_word(got, `WORD_RESET, "reset value");
        end
        nmac_host_model_i.rd(8'h40, got);
        cmp_word(got, 32'h0000_0000, "unmapped read");
        $display("test reset done");
        // every form against both overflow directions and two clean cases
        for (int f = 0; f < 8; f++) begin
            run_op(3'(f), 32'hffff_8000, 32'h1234_0001, `SAT_POS_VALUE, 1'b0);
            run_op(3'(f), 32'h0000_8000, 32'hffff_8000, `SAT_NEG_VALUE, 1'b0);
            run_op(3'(f), 32'h5555_7fff, 32'haaaa_7fff, 32'h3fff_0001, 1'b0);
            run_op(3'(f), 32'h0000_0002, 32'h0000_0003, 32'h0000_0006, 1'b0);
        end
        $display("test corners done");
        // chained runs reuse the accumulator left by the previous operation
        for (int i = 0; i < 40; i++) begin
            r = $random(seed);
            run_op(r[2:0], $random(seed), $random(seed), $random(seed), i > 0 && r[3]);
        end
        $display("test random done");
        // a second command, an accumulator write and a status clear each land in an execute cycle
        nmac_host_model_i.wr(`OFS_FIXED_EXC, 32'h0000_0000);
        nmac_host_model_i.wr(`OFS_SRC_A, 32'h0000_0003);
        nmac_host_model_i.wr(`OFS_SRC_B, 32'h0000_0005);
        nmac_host_model_i.wr(`OFS_DEST_ACCUM, 32'h0000_0020);
        nmac_host_model_i.wr(`OFS_COMMAND, 32'h0000_0002);
        nmac_host_model_i.wr(`OFS_COMMAND, 32'h0000_0001);
        nmac_host_model_i.wr(`OFS_COMMAND, 32'h0000_0000);
        nmac_host_model_i.wr(`OFS_DEST_ACCUM, 32'h0000_0100);
        nmac_host_model_i.wr(`OFS_COMMAND, 32'h0000_0000);
        nmac_host_model_i.wr(`OFS_IRQ_STATUS, 32'h0000_0003);
        nmac_host_model_i.idle();
        nmac_host_model_i.rd(`OFS_DEST_ACCUM, got);
        cmp_word(got, 32'hffff_fff3, "execute wins over writes");
        nmac_host_model_i.rd(`OFS_COND_ZERO, got);
        cmp_word(got, 32'h0000_0004, "record then base forms");
        nmac_host_model_i.rd(`OFS_IRQ_STATUS, got);
        cmp_word(got, 32'h0000_0001, "done event beats clear");
        $display("test collide done");
        nmac_host_model_i.wr(`OFS_IRQ_MASK, 32'h0000_0003);
        nmac_host_model_i.idle();
        #1 cmp_bit(irq, 1'b1, "irq raised");
        nmac_host_model_i.wr(`OFS_IRQ_STATUS, 32'h0000_0003);
        nmac_host_model_i.rd(`OFS_IRQ_STATUS, got);
        cmp_word(got, 32'h0000_0000, "irq cleared");
        cmp_bit(irq, 1'b0, "irq dropped");
        $display("test irq done");
        close_out();
    end
endmodule

// ---- nmac_arith.sv ----
`timescale 1ns/1ps
`include "nmac_consts.svh"

module nmac_arith (
    // operands
    input  wire logic [31:0]          src_a,
    input  wire logic [31:0]          src_b,
    input  wire logic [31:0]          acc,
    input  wire logic                 saturate,
    // result
    output nmac_pkg::mac_result_t     result
);

    function automatic logic [32:0] sext33(input logic [31:0] v);
        return {v[31], v};
    endfunction

    logic signed [31:0] product;
    logic        [32:0] diff;
    logic               ovf;

    // low halfwords only, signed 16x16 always fits 32 bits
    assign product = $signed(src_a[15:0]) * $signed(src_b[15:0]);
    // subtract at 33 bits so the carry out is kept
    assign diff = sext33(acc) - sext33(product);
    assign ovf  = diff[32] ^ diff[31];

    always_comb begin
        result.diff     = diff;
        result.overflow = ovf;
        if (saturate && ovf) begin
            result.value = diff[32] ? `SAT_NEG_VALUE : `SAT_POS_VALUE;
        end else begin
            result.value = diff[31:0];
        end
    end

endmodule

// ---- nmac_cond.sv ----
`timescale 1ns/1ps

module nmac_cond (
    // stored result and summary flag
    input  wire logic [31:0]          value,
    input  wire logic                 sticky,
    // condition field
    output nmac_pkg::cond_field_t     field
);

    always_comb begin
        field.lt = value[31];
        field.gt = ~value[31] & (|value);
        field.eq = ~(|value);
        field.so = sticky;
    end

endmodule

// ---- nmac_consts.svh ----
`ifndef NMAC_CONSTS_SVH
`define NMAC_CONSTS_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define OFS_SRC_A       8'h00
`define OFS_SRC_B       8'h04
`define OFS_DEST_ACCUM  8'h08
`define OFS_COMMAND     8'h0c
`define OFS_FIXED_EXC   8'h10
`define OFS_COND_ZERO   8'h14
`define OFS_IRQ_STATUS  8'h18
`define OFS_IRQ_MASK    8'h1c
`define OFS_CORE_STATUS 8'h20

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define EXC_ARITH_BIT   0
`define EXC_STICKY_BIT  1
`define IRQ_DONE_BIT    0
`define IRQ_OVF_BIT     1
`define STAT_BUSY_BIT   0
`define CMD_FORM_LSB    0
`define CMD_FORM_MSB    2

// ----------------------------------------------------------------------------
// values
// ----------------------------------------------------------------------------
`define WORD_RESET      32'h0000_0000
`define SAT_POS_VALUE   32'h7fff_ffff
`define SAT_NEG_VALUE   32'h8000_0000

`endif

// ---- nmac_host_model.sv ----
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// pipeline control side: issues register writes and reads
// ----------------------------------------------------------------------------
module nmac_host_model (
    // clock
    input  wire logic        clk,
    // register port
    output logic      [7:0]  addr,
    output logic      [31:0] wr_data,
    output logic             wr_en,
    output logic             rd_en,
    input  wire logic [31:0] rd_data
);
    initial begin
        addr = 8'h00;
        wr_data = 32'h0000_0000;
        wr_en = 1'b0;
        rd_en = 1'b0;
    end

    // one-cycle write; consecutive calls give back-to-back strobes
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        rd_en   <= 1'b0;
    endtask

    // released lines toggle so a stale value is never mistaken for a live one
    task automatic idle();
        @(posedge clk);
        wr_en   <= 1'b0;
        rd_en   <= 1'b0;
        addr    <= ~addr;
        wr_data <= ~wr_data;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wr_en <= 1'b0;
        rd_en <= 1'b1;
        idle();
        #1;
        d = rd_data;
    endtask
endmodule

// ---- nmac_low_core.sv ----
// Notes on behaviour
// - multiply low halfwords of both sources
// - halfwords signed, product is 32 bits
// - subtract product from accumulator at 33 bits
// - modulo forms keep low 32 bits
// - saturating forms clamp to nearest representable
// - base forms write accumulator only
// - record forms update condition field only
// - overflow forms update overflow flags only
// - overflow record forms update flags and field
// - accumulator is both input and destination
//
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "nmac_consts.svh"

module nmac_low_core (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // register port
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wr_data,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic      [31:0] rd_data,
    // status
    output logic             irq,
    output logic             busy
);

    // ------------------------------------------------------------------------
    // state and helpers
    // ------------------------------------------------------------------------
    nmac_pkg::core_state_t   cur_reg;
    nmac_pkg::core_state_t   cur_next;
    nmac_pkg::mac_result_t   res;
    nmac_pkg::cond_field_t   cond;
    logic                    exec;
    logic                    sat_form;
    logic                    rec_form;
    logic                    ovf_form;
    logic                    sw_sticky;
    logic                    sticky_after;
    logic [1:0]              events;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    assign exec     = cur_reg.fsm == nmac_pkg::ST_EXEC;
    assign sat_form = cur_reg.form[0];
    assign rec_form = cur_reg.form[1];
    assign ovf_form = cur_reg.form[2];

    // ------------------------------------------------------------------------
    // datapath
    // ------------------------------------------------------------------------
    nmac_arith u_arith (
        .src_a    (cur_reg.src_a),
        .src_b    (cur_reg.src_b),
        .acc      (cur_reg.acc),
        .saturate (sat_form),
        .result   (res)
    );

    // the field must see the summary flag as it stands after this operation
    assign sw_sticky    = (wr_en && hit(addr, `OFS_FIXED_EXC)) ? wr_data[`EXC_STICKY_BIT] : cur_reg.sticky_ov;
    assign sticky_after = sw_sticky | (exec & ovf_form & res.overflow);

    nmac_cond u_cond (
        .value  (res.value),
        .sticky (sticky_after),
        .field  (cond)
    );

    assign events[`IRQ_DONE_BIT] = exec;
    assign events[`IRQ_OVF_BIT]  = exec & res.overflow;

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb begin
        cur_next = cur_reg;

        // sequencer: one command, one execute cycle; commands while busy are dropped
        case (cur_reg.fsm)
            nmac_pkg::ST_IDLE: begin
                if (wr_en && hit(addr, `OFS_COMMAND)) begin
                    cur_next.fsm  = nmac_pkg::ST_EXEC;
                    cur_next.form = nmac_pkg::form_t'(wr_data[`CMD_FORM_MSB:`CMD_FORM_LSB]);
                end
            end
            nmac_pkg::ST_EXEC: begin
                cur_next.fsm = nmac_pkg::ST_IDLE;
            end
            default: begin
                cur_next.fsm = nmac_pkg::ST_IDLE;
            end
        endcase

        // software writes come first; the execute cycle overrides them below
        if (wr_en) begin
            if (hit(addr, `OFS_SRC_A)) begin
                cur_next.src_a = wr_data;
            end
            if (hit(addr, `OFS_SRC_B)) begin
                cur_next.src_b = wr_data;
            end
            if (hit(addr, `OFS_DEST_ACCUM)) begin
                cur_next.acc = wr_data;
            end
            if (hit(addr, `OFS_FIXED_EXC)) begin
                cur_next.arith_ov  = wr_data[`EXC_ARITH_BIT];
                cur_next.sticky_ov = wr_data[`EXC_STICKY_BIT];
            end
            if (hit(addr, `OFS_COND_ZERO)) begin
                cur_next.cr0 = nmac_pkg::cond_field_t'(wr_data[3:0]);
            end
            if (hit(addr, `OFS_IRQ_STATUS)) begin
                cur_next.irq_stat = cur_reg.irq_stat & ~wr_data[1:0];
            end
            if (hit(addr, `OFS_IRQ_MASK)) begin
                cur_next.irq_mask = wr_data[1:0];
            end
        end

        // a new event wins over a write-one-to-clear in the same cycle
        cur_next.irq_stat = cur_next.irq_stat | events;

        if (exec) begin
            cur_next.acc = res.value;
            if (ovf_form) begin
                cur_next.arith_ov  = res.overflow;
                cur_next.sticky_ov = sticky_after;
            end
            if (rec_form) begin
                cur_next.cr0 = cond;
            end
            // base forms touch neither the flags nor the field
        end

        // read data valid the cycle after the strobe only
        cur_next.rdata = `WORD_RESET;
        if (rd_en) begin
            case (addr)
                `OFS_SRC_A:       cur_next.rdata = cur_reg.src_a;
                `OFS_SRC_B:       cur_next.rdata = cur_reg.src_b;
                `OFS_DEST_ACCUM:  cur_next.rdata = cur_reg.acc;
                `OFS_COMMAND:     cur_next.rdata = {29'h000_0000, cur_reg.form};
                `OFS_FIXED_EXC:   cur_next.rdata = {30'h000_0000, cur_reg.sticky_ov, cur_reg.arith_ov};
                `OFS_COND_ZERO:   cur_next.rdata = {28'h000_0000, cur_reg.cr0};
                `OFS_IRQ_STATUS:  cur_next.rdata = {30'h000_0000, cur_reg.irq_stat};
                `OFS_IRQ_MASK:    cur_next.rdata = {30'h000_0000, cur_reg.irq_mask};
                `OFS_CORE_STATUS: cur_next.rdata = {31'h000_0000, cur_reg.busy};
                default:          cur_next.rdata = `WORD_RESET;
            endcase
        end

        cur_next.irq  = |(cur_next.irq_stat & cur_next.irq_mask);
        cur_next.busy = cur_next.fsm == nmac_pkg::ST_EXEC;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_reg <= '0;
        end else begin
            cur_reg <= cur_next;
        end
    end

    assign rd_data = cur_reg.rdata;
    assign irq     = cur_reg.irq;
    assign busy    = cur_reg.busy;

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    logic signed [31:0] ref_prod;
    logic        [32:0] ref_diff;
    logic               quiet;

    // reference built apart from the datapath, from the low halfwords only
    assign ref_prod = $signed(cur_reg.src_a[15:0]) * $signed(cur_reg.src_b[15:0]);
    assign ref_diff = {cur_reg.acc[31], cur_reg.acc} - {ref_prod[31], ref_prod};
    assign quiet    = !wr_en;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_cmd;
        wr_en && hit(addr, `OFS_COMMAND) && !exec;
    endsequence

    sequence s_exec_done;
        exec && quiet ##1 !exec;
    endsequence

    property p_low_halves;
        exec |-> res.diff == ref_diff;
    endproperty
    a_low_halves: assert property (p_low_halves) else $error("difference not from low halfwords");

    property p_signed_product;
        exec && (cur_reg.src_a[15] != cur_reg.src_b[15]) && (|cur_reg.src_a[15:0]) && (|cur_reg.src_b[15:0])
            |-> $signed(res.diff) > $signed({cur_reg.acc[31], cur_reg.acc});
    endproperty
    a_signed_product: assert property (p_signed_product) else $error("negative product not handled as signed");

    property p_wide_diff;
        exec |-> res.overflow == (ref_diff[32] != ref_diff[31]);
    endproperty
    a_wide_diff: assert property (p_wide_diff) else $error("overflow not seen at 33 bits");

    property p_modulo;
        exec && !sat_form |=> cur_reg.acc == $past(ref_diff[31:0]);
    endproperty
    a_modulo: assert property (p_modulo) else $error("modulo result not low 32 bits");

    property p_saturate;
        exec && sat_form && (ref_diff[32] != ref_diff[31])
            |=> cur_reg.acc == ($past(ref_diff[32]) ? `SAT_NEG_VALUE : `SAT_POS_VALUE);
    endproperty
    a_saturate: assert property (p_saturate) else $error("saturated value wrong");

    property p_base_form;
        s_exec_done and (exec && !ovf_form && !rec_form) |-> $stable(cur_reg.cr0) && $stable(cur_reg.arith_ov)
            && $stable(cur_reg.sticky_ov);
    endproperty
    a_base_form: assert property (p_base_form) else $error("base form changed flags or field");

    property p_record_form;
        exec && quiet && rec_form && !ovf_form
            |=> cur_reg.cr0.eq == (cur_reg.acc == `WORD_RESET) && $stable(cur_reg.arith_ov) && $stable(cur_reg.sticky_ov);
    endproperty
    a_record_form: assert property (p_record_form) else $error("record form field or flags wrong");

    property p_ovf_form;
        exec && quiet && ovf_form && !rec_form |=> cur_reg.arith_ov == $past(res.overflow) && $stable(cur_reg.cr0);
    endproperty
    a_ovf_form: assert property (p_ovf_form) else $error("overflow form flags or field wrong");

    property p_ovf_rec_form;
        exec && quiet && ovf_form && rec_form
            |=> cur_reg.arith_ov == $past(res.overflow) && cur_reg.cr0.so == cur_reg.sticky_ov
            && cur_reg.cr0.lt == cur_reg.acc[31];
    endproperty
    a_ovf_rec_form: assert property (p_ovf_rec_form) else $error("overflow record form update incomplete");

    property p_accumulate;
        s_cmd ##1 exec |=> cur_reg.acc == $past(res.value) && !busy;
    endproperty
    a_accumulate: assert property (p_accumulate) else $error("accumulator not written back");

    property p_sticky;
        exec && ovf_form && res.overflow |=> cur_reg.sticky_ov && cur_reg.arith_ov ##1 (cur_reg.sticky_ov || $past(!quiet));
    endproperty
    a_sticky: assert property (p_sticky) else $error("overflow did not set both flags");

    property p_cond_compare;
        exec && quiet && rec_form
            |=> cur_reg.cr0.gt == (!cur_reg.acc[31] && cur_reg.acc != `WORD_RESET)
            && cur_reg.cr0.so == cur_reg.sticky_ov;
    endproperty
    a_cond_compare: assert property (p_cond_compare) else $error("condition field compare wrong");

    // ------------------------------------------------------------------------
    // checks: collisions with the execute cycle, register port, status
    // ------------------------------------------------------------------------
    sequence s_cmd_in_exec;
        exec && wr_en && hit(addr, `OFS_COMMAND);
    endsequence

    sequence s_clear_in_exec;
        exec && wr_en && hit(addr, `OFS_IRQ_STATUS);
    endsequence

    property p_cmd_dropped;
        s_cmd_in_exec
            |=> !exec && cur_reg.form == $past(cur_reg.form);
    endproperty
    a_cmd_dropped: assert property (p_cmd_dropped) else $error("command taken while busy");

    property p_busy_pulse;
        s_cmd
            |=> busy ##1 !busy;
    endproperty
    a_busy_pulse: assert property (p_busy_pulse) else $error("busy not one cycle");

    property p_form_latched;
        s_cmd
            |=> cur_reg.form == $past(wr_data[`CMD_FORM_MSB:`CMD_FORM_LSB]);
    endproperty
    a_form_latched: assert property (p_form_latched) else $error("form not taken from command");

    property p_event_wins;
        s_clear_in_exec
            |=> cur_reg.irq_stat[`IRQ_DONE_BIT];
    endproperty
    a_event_wins: assert property (p_event_wins) else $error("clear beat done event");

    property p_ovf_event;
        exec && res.overflow
            |=> cur_reg.irq_stat[`IRQ_OVF_BIT];
    endproperty
    a_ovf_event: assert property (p_ovf_event) else $error("overflow event lost");

    property p_acc_write_loses;
        exec && wr_en && hit(addr, `OFS_DEST_ACCUM)
            |=> cur_reg.acc == $past(res.value);
    endproperty
    a_acc_write_loses: assert property (p_acc_write_loses) else $error("accumulator write beat result");

    property p_sat_in_range;
        exec && sat_form && !res.overflow
            |=> cur_reg.acc == $past(ref_diff[31:0]);
    endproperty
    a_sat_in_range: assert property (p_sat_in_range) else $error("saturating form changed in-range value");

    property p_field_kept;
        exec && quiet && !rec_form
            |=> $stable(cur_reg.cr0);
    endproperty
    a_field_kept: assert property (p_field_kept) else $error("field changed by non-record form");

    property p_flags_kept;
        exec && quiet && !ovf_form
            |=> $stable(cur_reg.arith_ov) && $stable(cur_reg.sticky_ov);
    endproperty
    a_flags_kept: assert property (p_flags_kept) else $error("flags changed by non-overflow form");

    property p_no_ovf_clears;
        exec && quiet && ovf_form && !res.overflow
            |=> !cur_reg.arith_ov && $stable(cur_reg.sticky_ov);
    endproperty
    a_no_ovf_clears: assert property (p_no_ovf_clears) else $error("clean result left flags wrong");

    property p_cr0_sign;
        exec && quiet && rec_form
            |=> cur_reg.cr0.lt == cur_reg.acc[31] && cur_reg.cr0.eq == (cur_reg.acc == `WORD_RESET);
    endproperty
    a_cr0_sign: assert property (p_cr0_sign) else $error("field sign or zero wrong");

    property p_read_idle;
        !rd_en
            |=> rd_data == `WORD_RESET;
    endproperty
    a_read_idle: assert property (p_read_idle) else $error("read data outside read cycle");

    property p_read_acc;
        rd_en && hit(addr, `OFS_DEST_ACCUM)
            |=> rd_data == $past(cur_reg.acc);
    endproperty
    a_read_acc: assert property (p_read_acc) else $error("accumulator read wrong");

    property p_read_flags;
        rd_en && hit(addr, `OFS_FIXED_EXC)
            |=> rd_data[1:0] == $past({cur_reg.sticky_ov, cur_reg.arith_ov});
    endproperty
    a_read_flags: assert property (p_read_flags) else $error("flag read wrong");

endmodule

// ---- nmac_pkg.sv ----
package nmac_pkg;

    // ------------------------------------------------------------------------
    // instruction forms: bit0 saturate, bit1 record, bit2 overflow enabled
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        NEG_MAC_LOW_MOD         = 3'b000,
        NEG_MAC_LOW_SAT         = 3'b001,
        NEG_MAC_LOW_MOD_REC     = 3'b010,
        NEG_MAC_LOW_SAT_REC     = 3'b011,
        NEG_MAC_LOW_MOD_OVF     = 3'b100,
        NEG_MAC_LOW_SAT_OVF     = 3'b101,
        NEG_MAC_LOW_MOD_OVF_REC = 3'b110,
        NEG_MAC_LOW_SAT_OVF_REC = 3'b111
    } form_t;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_EXEC = 1'b1
    } fsm_t;

    typedef struct packed {
        logic lt;
        logic gt;
        logic eq;
        logic so;
    } cond_field_t;

    typedef struct packed {
        logic [32:0] diff;
        logic        overflow;
        logic [31:0] value;
    } mac_result_t;

    typedef struct packed {
        fsm_t        fsm;
        form_t       form;
        logic [31:0] src_a;
        logic [31:0] src_b;
        logic [31:0] acc;
        logic        arith_ov;
        logic        sticky_ov;
        cond_field_t cr0;
        logic [1:0]  irq_stat;
        logic [1:0]  irq_mask;
        logic [31:0] rdata;
        logic        irq;
        logic        busy;
    } core_state_t;

endpackage
